// *** aio_pkg.sv ***
`default_nettype none
package aio_pkg;

  // record layout, byte offsets into the 12-byte diagnostic area
  localparam logic [3:0] AIO_OFS_FAULT    = 4'h0;
  localparam logic [3:0] AIO_OFS_CLASS    = 4'h1;
  localparam logic [3:0] AIO_OFS_SPARE_A  = 4'h2;
  localparam logic [3:0] AIO_OFS_SPARE_B  = 4'h3;
  localparam logic [3:0] AIO_OFS_CHTYPE   = 4'h4;
  localparam logic [3:0] AIO_OFS_DIAGBITS = 4'h5;
  localparam logic [3:0] AIO_OFS_CHCOUNT  = 4'h6;
  localparam logic [3:0] AIO_OFS_CHERR    = 4'h7;
  localparam logic [3:0] AIO_OFS_IN01     = 4'h8;
  localparam logic [3:0] AIO_OFS_IN23     = 4'h9;
  localparam logic [3:0] AIO_OFS_OUT45    = 4'hA;
  localparam logic [3:0] AIO_OFS_SPARE_C  = 4'hB;
  localparam int         AIO_REC_BYTES    = 12;
  localparam int         AIO_REC0_BYTES   = 4;

  // fault byte bit positions
  localparam int AIO_FB_MALFUNC   = 0;
  localparam int AIO_FB_EXT_ERR   = 2;
  localparam int AIO_FB_CH_ERR    = 3;
  localparam int AIO_FB_NO_SUPPLY = 4;
  localparam int AIO_FB_BAD_PARAM = 7;

  // fixed and reset contents
  localparam logic [7:0] AIO_RST_FAULT    = 8'h00;
  localparam logic [7:0] AIO_RST_CLASS    = 8'h15;
  localparam logic [3:0] AIO_CLASS_ANALOG = 4'h5;
  localparam int         AIO_CB_CHINFO    = 4;
  localparam logic [7:0] AIO_RST_CHTYPE   = 8'h74;
  localparam logic [7:0] AIO_RST_DIAGBITS = 8'h04;
  localparam logic [7:0] AIO_RST_CHCOUNT  = 8'h06;
  localparam logic [7:0] AIO_RST_ZERO     = 8'h00;

  // value scaling
  localparam int          AIO_IN_CH      = 4;
  localparam int          AIO_OUT_CH     = 2;
  localparam logic [31:0] AIO_FULL_SCALE = 32'h0000_6C00; // 27648
  localparam logic [31:0] AIO_SPAN_BIP   = 32'h0000_D800; // 2 * 27648

  typedef logic [AIO_REC_BYTES*8-1:0] aio_rec_t;

  // module-level fault inputs
  typedef struct packed {
    logic bad_param;
    logic no_supply;
    logic ext_err;
    logic malfunction;
  } aio_fault_t;

  // per-channel diagnostic groups
  typedef struct packed {
    logic [1:0]  out5;  // {param error, wire break/short}
    logic [1:0]  out4;
    logic [15:0] in03;  // 4 bits per input, channel 0 lowest
  } aio_chdiag_t;

  // reset contents of the whole area, byte 0 in the low bits
  localparam aio_rec_t AIO_REC_RESET = {
    AIO_RST_ZERO, AIO_RST_ZERO, AIO_RST_ZERO, AIO_RST_ZERO,
    AIO_RST_ZERO, AIO_RST_CHCOUNT, AIO_RST_DIAGBITS, AIO_RST_CHTYPE,
    AIO_RST_ZERO, AIO_RST_ZERO, AIO_RST_CLASS, AIO_RST_FAULT};

endpackage
`default_nettype wire

// *** aio_scale.sv ***
`default_nettype none
module aio_scale
  import aio_pkg::*;
(
  input  wire logic        mclk,      // system clock
  input  wire logic        srst,      // sync reset
  input  wire logic [15:0] raw_code,  // converter code, 0 = low limit
  input  wire logic        bipolar,   // 1 = symmetric range
  output logic      [15:0] value      // two's complement word
);

  logic [31:0] prod;

  // span is mapped to 0..27648 or -27648..27648; the top code stays
  // just below full scale, which trades one lsb for a shift-only divide
  always_comb begin
    prod = {16'h0000, raw_code} * (bipolar ? AIO_SPAN_BIP : AIO_FULL_SCALE);
  end

  // sign lands in bit 15 (byte 1 bit 7), two's complement value bits below it
  always_ff @(posedge mclk) begin
    if (srst) begin
      value <= 16'h0000;
    end else if (bipolar) begin
      value <= prod[31:16] - AIO_FULL_SCALE[15:0];
    end else begin
      value <= prod[31:16];
    end
  end

endmodule
`default_nettype wire

// *** aio_diag_mem.sv ***
`default_nettype none
module aio_diag_mem
  import aio_pkg::*;
(
  input  wire logic       mclk,     // system clock
  input  wire logic       srst,     // sync reset
  input  wire logic       wr_en,    // load the whole area
  input  wire aio_rec_t   wr_data,  // new area contents
  input  wire logic [3:0] rd_addr,  // byte address
  output logic      [7:0] rd_data   // registered read byte
);

  logic [7:0] mem [AIO_REC_BYTES];

  // whole-area write keeps the bytes mutually consistent
  always_ff @(posedge mclk) begin
    for (int i = 0; i < AIO_REC_BYTES; i++) begin
      if (srst) begin
        mem[i] <= AIO_REC_RESET[i*8 +: 8];
      end else if (wr_en) begin
        mem[i] <= wr_data[i*8 +: 8];
      end
    end
  end

  // addresses past the area read as zero
  always_ff @(posedge mclk) begin
    if (srst) begin
      rd_data <= 8'h00;
    end else if (rd_addr <= AIO_OFS_SPARE_C) begin
      rd_data <= mem[rd_addr];
    end else begin
      rd_data <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// *** aio_diag_top.sv ***
`default_nettype none
// How it works
// - value word: two's complement, low byte and high byte bits 0-6 value, bit 7 sign
// - bipolar ranges give -27648, 0, +27647 at low, zero, top code
// - live-zero ranges give 0 at low limit, 27647 at top code
// - twelve diagnostic bytes kept as record 0 and record 1
// - with alarm enabled, a detected error pushes record 0 to controller
// - record 0 is four bytes with fixed layout
// - fault byte: malfunction, external, channel, supply, parameter bits
// - class byte: analog class 0101, channel info flag, reads 15h
// - record 1 repeats record 0 then eight module bytes
// - channel type byte reads 74h
// - diagnostic bits per channel 04h, identical channels 06h
// - channel error byte: one bit per channel 0 to 5
// - input diag nibbles: wire break, parameter, underflow, overflow
// - output diag byte: channel 4 bits 0-1, channel 5 bits 4-5
// - after an alarm the data stay frozen until the handler finishes
module aio_diag_top
  import aio_pkg::*;
(
  input  wire logic         mclk,         // 20 MHz system clock
  input  wire logic         srst,         // sync reset, active high
  input  wire aio_fault_t   fault_pin,    // module fault pins, async
  input  wire aio_chdiag_t  chdiag_pin,   // channel diag pins, async
  input  wire logic         alarm_en,     // parameter byte 0 alarm enable
  input  wire logic [63:0]  raw_codes,    // 4 x 16-bit converter codes
  input  wire logic [3:0]   range_bip,    // per input: bipolar range
  input  wire logic         rd_req,       // controller byte read strobe
  input  wire logic [3:0]   rd_addr,      // byte offset 0..11
  input  wire logic         handler_done, // diagnostic handler finished
  output logic      [7:0]   rd_data,      // read byte
  output logic              rd_valid,     // read byte valid pulse
  output logic              alarm_req,    // record 0 pushed, held
  output logic      [31:0]  alarm_rec0,   // pushed record 0, byte 0 low
  output logic              frozen,       // data held for the handler
  output logic      [63:0]  meas_values   // 4 x scaled values
);

  typedef enum logic [1:0] {
    AIO_TRACK = 2'b01,
    AIO_HOLD  = 2'b10
  } aio_state_t;

  aio_state_t  state;
  aio_state_t  next_state;
  aio_fault_t  fault_m;
  aio_fault_t  fault_s;
  aio_chdiag_t chdiag_m;
  aio_chdiag_t chdiag_s;
  logic [5:0]  ch_err;
  logic        ch_err_any;
  logic [7:0]  fault_byte;
  logic [7:0]  class_byte;
  aio_rec_t    live_rec;
  logic [9:0]  err_vec;
  logic [9:0]  err_prev;
  logic        new_err;
  logic        pending;
  logic        raise;
  logic        mem_wr;
  logic [7:0]  mem_rd_data;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: first stage is read only by the second

  always_ff @(posedge mclk) begin
    if (srst) begin
      fault_m  <= '0;
      fault_s  <= '0;
      chdiag_m <= '0;
      chdiag_s <= '0;
    end else begin
      fault_m  <= fault_pin;
      fault_s  <= fault_m;
      chdiag_m <= chdiag_pin;
      chdiag_s <= chdiag_m;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // live record assembly

  // a channel counts as faulty when any of its diag bits is up
  always_comb begin
    for (int c = 0; c < AIO_IN_CH; c++) begin
      ch_err[c] = |chdiag_s.in03[c*4 +: 4];
    end
    ch_err[4]  = |chdiag_s.out4;
    ch_err[5]  = |chdiag_s.out5;
    ch_err_any = |ch_err;
  end

  // fault byte: unlisted bits stay zero
  always_comb begin
    fault_byte                   = AIO_RST_FAULT;
    fault_byte[AIO_FB_MALFUNC]   = fault_s.malfunction;
    fault_byte[AIO_FB_EXT_ERR]   = fault_s.ext_err;
    fault_byte[AIO_FB_CH_ERR]    = ch_err_any;
    fault_byte[AIO_FB_NO_SUPPLY] = fault_s.no_supply;
    fault_byte[AIO_FB_BAD_PARAM] = fault_s.bad_param;
  end

  // class byte is a constant: analog class with channel info present
  always_comb begin
    class_byte                = 8'h00;
    class_byte[3:0]           = AIO_CLASS_ANALOG;
    class_byte[AIO_CB_CHINFO] = 1'b1;
  end

  // bytes 0..3 form record 0, record 1 is the whole area
  always_comb begin
    live_rec = {
      AIO_RST_ZERO,
      2'b00, chdiag_s.out5, 2'b00, chdiag_s.out4,
      chdiag_s.in03[15:8],
      chdiag_s.in03[7:0],
      2'b00, ch_err,
      AIO_RST_CHCOUNT,
      AIO_RST_DIAGBITS,
      AIO_RST_CHTYPE,
      AIO_RST_ZERO, AIO_RST_ZERO,
      class_byte, fault_byte};
  end

  ////////////////////////////////////////////////////////////////////////
  // error event detection: any flag that newly rises is an event

  assign err_vec = {fault_s.bad_param, fault_s.no_supply, fault_s.ext_err,
                    fault_s.malfunction, ch_err};
  assign new_err = |(err_vec & ~err_prev);

  always_ff @(posedge mclk) begin
    if (srst) begin
      err_prev <= '0;
    end else begin
      err_prev <= err_vec;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // alarm sequencing

  // an event seen while held waits here; set beats the clear so an
  // error arriving with handler_done still gets its own alarm
  always_ff @(posedge mclk) begin
    if (srst) begin
      pending <= 1'b0;
    end else if (alarm_en && new_err && state == AIO_HOLD) begin
      pending <= 1'b1;
    end else if (state == AIO_TRACK) begin
      pending <= 1'b0;
    end
  end

  assign raise = alarm_en && (new_err || pending);

  always_comb begin
    case (state)
      AIO_TRACK: next_state = raise ? AIO_HOLD : AIO_TRACK;
      AIO_HOLD:  next_state = handler_done ? AIO_TRACK : AIO_HOLD;
      default:   next_state = AIO_TRACK;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= AIO_TRACK;
    end else begin
      state <= next_state;
    end
  end

  // push record 0 on entry to hold
  always_ff @(posedge mclk) begin
    if (srst) begin
      alarm_req  <= 1'b0;
      alarm_rec0 <= AIO_REC_RESET[AIO_REC0_BYTES*8-1:0];
    end else if (state == AIO_TRACK && raise) begin
      alarm_req  <= 1'b1;
      alarm_rec0 <= live_rec[AIO_REC0_BYTES*8-1:0];
    end else if (state == AIO_HOLD && handler_done) begin
      alarm_req  <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      frozen <= 1'b0;
    end else begin
      frozen <= (next_state == AIO_HOLD);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // diagnostic area storage and read port

  // the area follows the live data except while the handler runs;
  // it captures the same snapshot that goes out as record 0
  assign mem_wr = (state == AIO_TRACK);

  aio_diag_mem u_mem (
    .mclk    (mclk),
    .srst    (srst),
    .wr_en   (mem_wr),
    .wr_data (live_rec),
    .rd_addr (rd_addr),
    .rd_data (mem_rd_data)
  );

  // one-cycle read latency; the memory output is already a register
  assign rd_data = mem_rd_data;

  always_ff @(posedge mclk) begin
    if (srst) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // measured value scaling, one converter per input channel

  for (genvar g = 0; g < AIO_IN_CH; g++) begin : g_scale
    aio_scale u_scale (
      .mclk     (mclk),
      .srst     (srst),
      .raw_code (raw_codes[g*16 +: 16]),
      .bipolar  (range_bip[g]),
      .value    (meas_values[g*16 +: 16])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence s_raise;
    state == AIO_TRACK && alarm_en && new_err;
  endsequence

  sequence s_held;
    frozen && alarm_req && state == AIO_HOLD;
  endsequence

  // a detected error with the alarm enabled pushes and freezes at once
  a_alarm_push: assert property (s_raise |=> s_held)
    else $error("alarm not raised on new error");

  // the pushed record is the snapshot taken on the raising edge
  a_push_content: assert property (
      s_raise |=> alarm_rec0 == $past(live_rec[31:0]))
    else $error("pushed record 0 differs from snapshot");

  // nothing the handler may read moves until it signs off
  a_hold_stable: assert property (
      state == AIO_HOLD && !handler_done
      |=> $stable(alarm_rec0) && !$past(mem_wr) && frozen)
    else $error("diagnostic data changed while held");

  // sign-off with nothing waiting goes back to tracking
  a_release_done: assert property (
      state == AIO_HOLD && handler_done && !pending && !new_err
      |=> (!alarm_req && !frozen && state == AIO_TRACK)
      ##1 (!frozen || alarm_req))
    else $error("hold not released after handler");

  // a disabled alarm never reaches the controller
  a_no_alarm_off: assert property (
      !alarm_en && !pending |=> !$rose(alarm_req))
    else $error("alarm raised while disabled");

  // layout checks on the live area, written apart from the assembly code
  a_fault_byte: assert property (
      live_rec[7:0] ==
      {fault_s.bad_param, 2'b00, fault_s.no_supply, (|chdiag_s),
       fault_s.ext_err, 1'b0, fault_s.malfunction})
    else $error("fault byte layout wrong");

  a_fixed_bytes: assert property (
      live_rec[15:8] == 8'h15 &&
      live_rec[39:32] == 8'h74 && live_rec[47:40] == 8'h04 &&
      live_rec[55:48] == 8'h06)
    else $error("fixed record bytes wrong");

  a_chan_flags: assert property (
      (|chdiag_s.in03[3:0]) == live_rec[56] &&
      (|chdiag_s.in03[15:12]) == live_rec[59] &&
      (|chdiag_s.out4) == live_rec[60] &&
      (|chdiag_s.out5) == live_rec[61])
    else $error("channel error flag mismatch");

  // unmapped offsets read zero one cycle after the strobe
  a_read_latency: assert property (
      rd_req && rd_addr > AIO_OFS_SPARE_C
      |=> rd_valid && rd_data == 8'h00)
    else $error("unmapped read not zero");

  // midpoint codes land on zero and on half scale
  a_bip_zero: assert property (
      range_bip[0] && raw_codes[15:0] == 16'h8000
      |=> meas_values[15:0] == 16'h0000)
    else $error("bipolar midpoint not zero");

  a_live_mid: assert property (
      !range_bip[0] && raw_codes[15:0] == 16'h8000
      |=> meas_values[15:0] == 16'h3600)
    else $error("live-zero midpoint not 13824");

endmodule
`default_nettype wire

// *** aio_ctrl_model.sv ***
`default_nettype none
module aio_ctrl_model
  import aio_pkg::*;
(
  input  wire logic       mclk,         // system clock
  input  wire logic       srst,         // sync reset
  input  wire logic       alarm_req,    // pushed record pending
  input  wire logic [7:0] hdl_delay,    // handler run time in cycles
  output logic            handler_done  // handler finished pulse
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] cnt;

  //////////////////////////////////////////////////////////////////////////
  // handler runs for hdl_delay+1 cycles, then signs off with one pulse;
  // it never signs off twice for one alarm, as a real handler would not
  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt          <= 8'h00;
      handler_done <= 1'b0;
    end else begin
      handler_done <= 1'b0;
      if (alarm_req && !handler_done) begin
        if (cnt >= hdl_delay) begin
          handler_done <= 1'b1;
          cnt          <= 8'h00;
        end else begin
          cnt <= cnt + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** tb_top.sv ***
`default_nettype none
module tb_top
  import aio_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  logic         mclk;
  logic         srst;
  aio_fault_t   fault_pin;
  aio_chdiag_t  chdiag_pin;
  logic         alarm_en;
  logic [63:0]  raw_codes;
  logic [3:0]   range_bip;
  logic         rd_req;
  logic [3:0]   rd_addr;
  logic         handler_done;
  logic [7:0]   rd_data;
  logic         rd_valid;
  logic         alarm_req;
  logic [31:0]  alarm_rec0;
  logic         frozen;
  logic [63:0]  meas_values;
  logic [7:0]   hdl_delay;
  int           n_fail;
  int           checks;
  logic [7:0]   rst_exp [16];
  logic [19:0]  dv [2];
  logic [39:0]  dexp [2];
  logic [3:0]   daddr [5];

  aio_diag_top u_aio_diag_top (
    .mclk         (mclk),
    .srst         (srst),
    .fault_pin    (fault_pin),
    .chdiag_pin   (chdiag_pin),
    .alarm_en     (alarm_en),
    .raw_codes    (raw_codes),
    .range_bip    (range_bip),
    .rd_req       (rd_req),
    .rd_addr      (rd_addr),
    .handler_done (handler_done),
    .rd_data      (rd_data),
    .rd_valid     (rd_valid),
    .alarm_req    (alarm_req),
    .alarm_rec0   (alarm_rec0),
    .frozen       (frozen),
    .meas_values  (meas_values)
  );

  aio_ctrl_model u_aio_ctrl_model (
    .mclk         (mclk),
    .srst         (srst),
    .alarm_req    (alarm_req),
    .hdl_delay    (hdl_delay),
    .handler_done (handler_done)
  );

  //////////////////////////////////////////////////////////////////////////
  // clock and watchdog; the tests need a few hundred cycles at most
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  initial begin
    #100000;
    n_fail++;
    finish_test();
  end

  //////////////////////////////////////////////////////////////////////////
  // helpers; inputs always move 1 ns after the rising edge
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // strobe is left high so that reads may run back to back
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    rd_req  = 1'b1;
    rd_addr = a;
    cyc(1);
    chk({63'h0, rd_valid}, 64'h1);
    chk({56'h0, rd_data}, {56'h0, e});
  endtask

  task automatic wt(input int n);
    rd_req = 1'b0;
    cyc(n);
  endtask

  // bounded wait for the alarm line to reach a level
  task automatic wait_lvl(input logic lvl);
    int i;
    i = 0;
    while (alarm_req !== lvl && i < 60) begin
      cyc(1);
      i++;
    end
    chk({63'h0, alarm_req}, {63'h0, lvl});
  endtask

  task automatic finish_test();
    if (n_fail == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    n_fail     = 0;
    checks     = 0;
    srst       = 1'b1;
    fault_pin  = 4'h0;
    chdiag_pin = 20'h00000;
    alarm_en   = 1'b0;
    raw_codes  = 64'h0;
    range_bip  = 4'h0;
    rd_req     = 1'b0;
    rd_addr    = 4'h0;
    hdl_delay  = 8'h14;
    rst_exp    = '{8'h00, 8'h15, 8'h00, 8'h00, 8'h74, 8'h04, 8'h06, 8'h00,
                   8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    dv         = '{20'h80040, 20'h18000};
    dexp       = '{40'h08_22_40_00_20, 40'h08_18_00_80_01};
    daddr      = '{AIO_OFS_FAULT, AIO_OFS_CHERR, AIO_OFS_IN01, AIO_OFS_IN23,
                   AIO_OFS_OUT45};
    cyc(4);
    srst = 1'b0;
    // reset contents, including the unmapped tail, read back to back
    chk({32'h0, alarm_rec0}, 64'h1500);
    for (int a = 0; a < 16; a++) begin
      rd(a[3:0], rst_exp[a]);
    end
    // mixed ranges: live-zero on ch0/ch1, bipolar on ch2/ch3; then the
    // ch0 midpoint in bipolar range and the top code just under full scale
    range_bip = 4'b1100;
    raw_codes = 64'h4000_0000_C000_8000;
    wt(2);
    chk(meas_values, 64'hCA00_9400_5100_3600);
    range_bip = 4'b0001;
    raw_codes = 64'hFFFF_0000_C000_8000;
    wt(2);
    chk(meas_values, 64'h6BFF_0000_5100_0000);
    // every module fault at once with the alarm disabled
    fault_pin = 4'hF;
    wt(4);
    rd(AIO_OFS_FAULT, 8'h95);
    wt(1);
    chk({63'h0, alarm_req}, 64'h0);
    fault_pin = 4'h0;
    // channel diagnostics land in their nibble and their summary bits
    for (int k = 0; k < 2; k++) begin
      chdiag_pin = dv[k];
      wt(4);
      for (int j = 0; j < 5; j++) begin
        rd(daddr[j], dexp[k][39-8*j -: 8]);
      end
    end
    chdiag_pin = 20'h00000;
    wt(4);
    // alarm push, a fault arriving while held, then the pending re-raise
    alarm_en  = 1'b1;
    fault_pin = 4'h2;
    wait_lvl(1'b1);
    chk({32'h0, alarm_rec0}, 64'h1504);
    chk({63'h0, frozen}, 64'h1);
    fault_pin = 4'h3;
    cyc(4);
    rd(AIO_OFS_FAULT, 8'h04);
    wt(1);
    hdl_delay = 8'h00;
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    chk({32'h0, alarm_rec0}, 64'h1505);
    wait_lvl(1'b0);
    fault_pin = 4'h0;
    alarm_en  = 1'b0;
    wt(4);
    rd(AIO_OFS_FAULT, 8'h00);
    wt(1);
    chk({63'h0, frozen}, 64'h0);
    finish_test();
  end
endmodule
`default_nettype wire
